// ---- inc/isctf_regs.vh ----
`ifndef ISCTF_REGS_VH
`define ISCTF_REGS_VH
// register byte addresses
`define ISCTF_ADDR_CLK 8'h1c
`define ISCTF_ADDR_RISE 8'h20
`define ISCTF_ADDR_CTRL 8'h24
`define ISCTF_ADDR_STAT 8'h28
// clock control fields
`define ISCTF_CLK_FAST 15
`define ISCTF_CLK_DUTY 14
`define ISCTF_CLK_DIV_HI 11
`define ISCTF_CLK_RESET 16'h0000
// rise time and filter fields
`define ISCTF_RISE_SCL_AF_OFF 31
`define ISCTF_RISE_SCL_AFW_LO 29
`define ISCTF_RISE_SDA_AF_OFF 28
`define ISCTF_RISE_SDA_AFW_LO 26
`define ISCTF_RISE_SCL_DF_LO 22
`define ISCTF_RISE_SDA_DF_LO 18
`define ISCTF_RISE_TR_HI 5
`define ISCTF_RISE_RESET 32'h0000_0002
// control fields
`define ISCTF_CTRL_EN 0
`define ISCTF_CTRL_MASTER 1
`define ISCTF_CTRL_RESET 2'h0
// duty multipliers
`define ISCTF_MUL_STD_LO 5'h01
`define ISCTF_MUL_STD_HI 5'h01
`define ISCTF_MUL_F2_LO 5'h02
`define ISCTF_MUL_F2_HI 5'h01
`define ISCTF_MUL_F169_LO 5'h10
`define ISCTF_MUL_F169_HI 5'h09
`endif

// ---- rtl/isctf_glitch_filter.v ----
`timescale 1ns/10ps
// digital glitch filter: output follows input once stable for len cycles
module isctf_glitch_filter (
  // clock and reset
  input wire ref_clk,
  input wire reset,
  // filter
  input wire [3:0] len,
  input wire din,
  output reg dout
);
  reg [3:0] cnt_reg;

  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cnt_reg <= 4'h0;
      dout <= 1'b1;
    end else if (len == 4'h0) begin
      cnt_reg <= 4'h0;
      dout <= din;
    end else if (din == dout) begin
      cnt_reg <= 4'h0;
    end else if (cnt_reg + 4'h1 >= len) begin
      cnt_reg <= 4'h0;
      dout <= din;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end
endmodule

// ---- rtl/isctf_scl_gen.v ----
`timescale 1ns/10ps
// scl generator: low phase count, wait for rise, then high phase count
module isctf_scl_gen (
  // clock and reset
  input wire ref_clk,
  input wire reset,
  // control
  input wire run,
  input wire [16:0] low_cycles,
  input wire [16:0] high_cycles,
  input wire [5:0] rise_limit,
  input wire scl_in,
  // outputs
  output reg scl_drive_low,
  output reg high_phase
);
  localparam ST_IDLE = 2'h0;
  localparam ST_LOW = 2'h1;
  localparam ST_RISE = 2'h2;
  localparam ST_HIGH = 2'h3;
  reg [1:0] state_reg;
  reg [16:0] cnt_reg;

  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 17'h0;
      scl_drive_low <= 1'b0;
      high_phase <= 1'b0;
    end else if (!run) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 17'h0;
      scl_drive_low <= 1'b0;
      high_phase <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          state_reg <= ST_LOW;
          cnt_reg <= 17'h1;
          scl_drive_low <= 1'b1;
          high_phase <= 1'b0;
        end
        ST_LOW: begin
          if (cnt_reg >= low_cycles) begin
            state_reg <= ST_RISE;
            cnt_reg <= 17'h0;
            scl_drive_low <= 1'b0;
          end else begin
            cnt_reg <= cnt_reg + 17'h1;
          end
        end
        ST_RISE: begin
          // wait for released line seen high or rise allowance used
          if (scl_in || cnt_reg >= {11'h0, rise_limit}) begin // RULE19
            state_reg <= ST_HIGH;
            cnt_reg <= 17'h1;
            high_phase <= 1'b1;
          end else begin
            cnt_reg <= cnt_reg + 17'h1;
          end
        end
        ST_HIGH: begin
          if (cnt_reg >= high_cycles) begin
            state_reg <= ST_LOW;
            cnt_reg <= 17'h1;
            scl_drive_low <= 1'b1;
            high_phase <= 1'b0;
          end else begin
            cnt_reg <= cnt_reg + 17'h1;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// ---- rtl/isctf_top.v ----
// How it works
// RULE1 - software writes clock register only when disabled
// RULE2 - bit 15 picks standard or fast mode
// RULE3 - bit 14 picks ratio 2 or 16/9
// RULE4 - 12-bit divider sets master scl period
// RULE5 - ratio 1:1 low and high equal divider
// RULE6 - ratio 2:1 low twice, high once divider
// RULE7 - ratio 16:9 low 16x, high 9x divider
// RULE8 - divider minimum 4 standard, 1 fast
// RULE9 - rise limit applies only as master
// RULE10 - rise/filter register changed only when disabled
// RULE11 - analog filter bit zero enables, one disables
// RULE12 - width codes give 5 to 35 ns
// RULE13 - scl digital filter zero off, else cycles
// RULE14 - sda digital filter zero off, else cycles
// RULE15 - six-bit maximum rise time in clocks
// RULE16 - software writes rise time over period plus one
// RULE17 - software may add filter delay to rise
// RULE18 - peripheral clock multiple of 10 MHz
// RULE19 - high phase starts after scl seen high; code also starts it once the rise allowance is used up
//
// The APB slave port is this design's own decision.
`timescale 1ns/10ps
`include "isctf_regs.vh"
module isctf_top (
  // clock and reset
  input wire ref_clk,
  input wire reset,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // i2c clock and data lines, open drain
  input wire scl_in,
  input wire sda_in,
  output reg scl_out,
  output reg scl_oe,
  // filtered lines
  output reg scl_filtered,
  output reg sda_filtered,
  // analog filter cell controls
  output reg scl_analog_filter_off,
  output reg [1:0] scl_analog_filter_width,
  output reg sda_analog_filter_off,
  output reg [1:0] sda_analog_filter_width
);
  reg [15:0] scl_timing_control_reg;
  reg [31:0] rise_time_and_filter_config_reg;
  reg [1:0] ctrl_reg;
  reg [31:0] rdata_next;
  reg [4:0] mul_lo;
  reg [4:0] mul_hi;
  wire setup;
  wire wr_ok;
  wire enabled;
  wire master;
  wire fast_speed_select;
  wire duty_sel;
  wire [11:0] scl_divider;
  wire [5:0] rise_time_limit;
  wire [5:0] rise_used;
  wire [3:0] scl_glitch_filter_len;
  wire [3:0] sda_glitch_filter_len;
  wire [16:0] low_cycles;
  wire [16:0] high_cycles;
  wire scl_f;
  wire sda_f;
  wire gen_low;
  wire gen_high;

  // phase length = multiplier times divider
  function [16:0] phase_len;
    input [4:0] mul;
    input [11:0] div;
    begin
      phase_len = mul * div;
    end
  endfunction

  assign setup = psel && !penable;
  assign wr_ok = setup && pwrite;
  assign enabled = ctrl_reg[`ISCTF_CTRL_EN];
  assign master = ctrl_reg[`ISCTF_CTRL_MASTER];
  assign fast_speed_select = scl_timing_control_reg[`ISCTF_CLK_FAST];
  assign duty_sel = scl_timing_control_reg[`ISCTF_CLK_DUTY];
  assign scl_divider =
    scl_timing_control_reg[`ISCTF_CLK_DIV_HI:0]; // RULE4
  assign rise_time_limit =
    rise_time_and_filter_config_reg[`ISCTF_RISE_TR_HI:0]; // RULE15
  assign scl_glitch_filter_len =
    rise_time_and_filter_config_reg[`ISCTF_RISE_SCL_DF_LO +: 4];
  assign sda_glitch_filter_len =
    rise_time_and_filter_config_reg[`ISCTF_RISE_SDA_DF_LO +: 4];
  // rise allowance only while master
  assign rise_used = master ? rise_time_limit : 6'h00; // RULE9

  // ratio selection
  always @* begin
    if (!fast_speed_select) begin // RULE2
      mul_lo = `ISCTF_MUL_STD_LO; // RULE5
      mul_hi = `ISCTF_MUL_STD_HI;
    end else if (!duty_sel) begin // RULE3
      mul_lo = `ISCTF_MUL_F2_LO; // RULE6
      mul_hi = `ISCTF_MUL_F2_HI;
    end else begin
      mul_lo = `ISCTF_MUL_F169_LO; // RULE7
      mul_hi = `ISCTF_MUL_F169_HI;
    end
  end

  assign low_cycles = phase_len(mul_lo, scl_divider);
  assign high_cycles = phase_len(mul_hi, scl_divider);

  // registers; apb answers in the access cycle
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      scl_timing_control_reg <= `ISCTF_CLK_RESET;
      rise_time_and_filter_config_reg <= `ISCTF_RISE_RESET;
      ctrl_reg <= `ISCTF_CTRL_RESET;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= 1'b0;
      if (setup) begin
        prdata <= pwrite ? 32'h0 : rdata_next;
        case (paddr)
          `ISCTF_ADDR_CLK, `ISCTF_ADDR_RISE, `ISCTF_ADDR_CTRL,
          `ISCTF_ADDR_STAT: pslverr <= 1'b0;
          default: pslverr <= 1'b1;
        endcase
      end
      // settings are ignored while enabled
      if (wr_ok && paddr == `ISCTF_ADDR_CLK && !enabled) begin // RULE1
        scl_timing_control_reg <= {pwdata[15:14], 2'h0, pwdata[11:0]};
      end
      if (wr_ok && paddr == `ISCTF_ADDR_RISE && !enabled) begin // RULE10
        rise_time_and_filter_config_reg <=
          {pwdata[31:18], 12'h000, pwdata[5:0]};
      end
      if (wr_ok && paddr == `ISCTF_ADDR_CTRL) begin
        ctrl_reg <= pwdata[1:0];
      end
    end
  end

  always @* begin
    case (paddr)
      `ISCTF_ADDR_CLK: rdata_next = {16'h0, scl_timing_control_reg};
      `ISCTF_ADDR_RISE: rdata_next = rise_time_and_filter_config_reg;
      `ISCTF_ADDR_CTRL: rdata_next = {30'h0, ctrl_reg};
      `ISCTF_ADDR_STAT:
        rdata_next = {28'h0, gen_high, scl_oe, sda_f, scl_f};
      default: rdata_next = 32'h0;
    endcase
  end

  isctf_glitch_filter u_scl_filter (
    .ref_clk(ref_clk),
    .reset(reset),
    .len(scl_glitch_filter_len), // RULE13
    .din(scl_in),
    .dout(scl_f)
  );

  isctf_glitch_filter u_sda_filter (
    .ref_clk(ref_clk),
    .reset(reset),
    .len(sda_glitch_filter_len), // RULE14
    .din(sda_in),
    .dout(sda_f)
  );

  isctf_scl_gen u_scl_gen (
    .ref_clk(ref_clk),
    .reset(reset),
    .run(enabled && master),
    .low_cycles(low_cycles),
    .high_cycles(high_cycles),
    .rise_limit(rise_used),
    .scl_in(scl_f),
    .scl_drive_low(gen_low),
    .high_phase(gen_high)
  );

  // output flops
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      scl_out <= 1'b0;
      scl_oe <= 1'b0;
      scl_filtered <= 1'b1;
      sda_filtered <= 1'b1;
      scl_analog_filter_off <= 1'b0;
      scl_analog_filter_width <= 2'h0;
      sda_analog_filter_off <= 1'b0;
      sda_analog_filter_width <= 2'h0;
    end else begin
      scl_out <= 1'b0;
      scl_oe <= gen_low;
      scl_filtered <= scl_f;
      sda_filtered <= sda_f;
      scl_analog_filter_off <=
        rise_time_and_filter_config_reg[`ISCTF_RISE_SCL_AF_OFF]; // RULE11
      sda_analog_filter_off <=
        rise_time_and_filter_config_reg[`ISCTF_RISE_SDA_AF_OFF];
      scl_analog_filter_width <=
        rise_time_and_filter_config_reg[`ISCTF_RISE_SCL_AFW_LO +: 2]; // RULE12
      sda_analog_filter_width <=
        rise_time_and_filter_config_reg[`ISCTF_RISE_SDA_AFW_LO +: 2];
    end
  end
endmodule

// ---- tb/isctf_sva.sv ----
`timescale 1ns/10ps
`include "isctf_regs.vh"
module isctf_sva (
  // clock and reset
  input wire ref_clk,
  input wire reset,
  // apb
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // lines
  input wire scl_in,
  input wire sda_in,
  input wire scl_out,
  input wire scl_oe,
  input wire scl_filtered,
  input wire sda_filtered,
  // analog filter controls
  input wire scl_analog_filter_off,
  input wire [1:0] scl_analog_filter_width,
  input wire sda_analog_filter_off,
  input wire [1:0] sda_analog_filter_width
);
  wire wr = psel && !penable && pwrite;
  wire rd = pready && !pwrite;
  wire map = paddr == `ISCTF_ADDR_CLK || paddr == `ISCTF_ADDR_RISE ||
    paddr == `ISCTF_ADDR_CTRL || paddr == `ISCTF_ADDR_STAT;
  wire [5:0] af = {scl_analog_filter_off, scl_analog_filter_width,
    sda_analog_filter_off, sda_analog_filter_width};
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  ready_answer_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  ready_cause_a: assert property (!(psel && !penable) |=> !pready)
    else $error("ready without setup");
  mapped_ok_a: assert property (pready && map |-> !pslverr)
    else $error("error on mapped address");
  unmapped_err_a: assert property (pready && !map |-> pslverr)
    else $error("no error on unmapped address");
  clk_rsvd_a: assert property (rd && paddr == `ISCTF_ADDR_CLK |->
    prdata[31:16] == 16'h0000 && prdata[13:12] == 2'h0)
    else $error("clock register reserved bits set");
  rise_rsvd_a: assert property (rd && paddr == `ISCTF_ADDR_RISE |->
    prdata[17:6] == 12'h000) else $error("rise register reserved bits set");
  scl_out_low_a: assert property (scl_out == 1'b0)
    else $error("scl driven high");
  af_hold_a: assert property (
    !$past(wr) && !$past(wr, 2) |-> $stable(af))
    else $error("analog filter controls moved without write");
  cover property (wr);
  cover property (pslverr);
  cover property ($rose(scl_oe));
endmodule

// ---- tb/isctf_bus_model.sv ----
`timescale 1ns/10ps
module isctf_bus_model (
  // clock
  input wire ref_clk,
  // bus controls
  input wire scl_oe,
  input wire [3:0] stretch,
  input wire sda_low,
  input wire scl_low,
  // line levels, pulled up
  output wire scl_in,
  output wire sda_in
);
  logic [3:0] hold_reg = 4'h0;
  // slave keeps scl low for stretch cycles after release
  always @(posedge ref_clk) begin
    if (scl_oe)
      hold_reg <= stretch;
    else if (hold_reg != 4'h0)
      hold_reg <= hold_reg - 4'h1;
  end
  assign scl_in = !(scl_oe || hold_reg != 4'h0 || scl_low);
  assign sda_in = !sda_low;
endmodule

// ---- tb/isctf_top_tb.sv ----
`timescale 1ns/10ps
`include "isctf_regs.vh"
module isctf_top_tb;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e, sda_low = 1'b0;
  logic scl_low = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, q, d, v;
  logic [3:0] stretch = 4'h0;
  wire [31:0] prdata;
  wire pready, pslverr, scl_in, sda_in, scl_out, scl_oe, scl_f, sda_f;
  wire scl_af, sda_af;
  wire [1:0] scl_aw, sda_aw;
  integer fails = 0, compares = 0, seed = 94289;
  integer n, m, k, dv, lo, hi, l, h, z, g, f, w;
  // 200 MHz is a whole multiple of 10 MHz
  always #2.5 ref_clk = ~ref_clk;
  isctf_top dut (.ref_clk(ref_clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl_in),
    .sda_in(sda_in), .scl_out(scl_out), .scl_oe(scl_oe),
    .scl_filtered(scl_f), .sda_filtered(sda_f),
    .scl_analog_filter_off(scl_af), .scl_analog_filter_width(scl_aw),
    .sda_analog_filter_off(sda_af), .sda_analog_filter_width(sda_aw));
  isctf_bus_model bus (.ref_clk(ref_clk), .scl_oe(scl_oe),
    .stretch(stretch), .sda_low(sda_low), .scl_low(scl_low),
    .scl_in(scl_in), .sda_in(sda_in));
  task chk(input logic [31:0] g, input logic [31:0] x);
    begin
      compares = compares + 1;
      if (g !== x) begin
        fails = fails + 1;
        $display("unexpected at %0t: got %h expected %h", $time, g, x);
      end
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    begin
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge ref_clk);
      penable <= 1'b1;
      // pready ends this wait; only the watchdog ends it if ready never comes
      do
        @(posedge ref_clk);
      while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // idle edge so a following call never re-drives in this time step
      @(posedge ref_clk);
    end
  endtask
  // lengths of one low and the following released phase
  task scl_phase;
    begin
      n = 0;
      while (scl_oe !== 1'b1 && n < 900) begin
        @(posedge ref_clk);
        n = n + 1;
      end
      l = 0;
      while (scl_oe === 1'b1 && l < 900) begin
        @(posedge ref_clk);
        l = l + 1;
      end
      h = 0;
      while (scl_oe !== 1'b1 && h < 900) begin
        @(posedge ref_clk);
        h = h + 1;
      end
    end
  endtask
  // low pulse on scl (sel 0) or sda, then count filtered low cycles
  task line_pulse(input integer sel, input integer len);
    begin
      if (sel == 0)
        scl_low <= 1'b1;
      else
        sda_low <= 1'b1;
      repeat (len) @(posedge ref_clk);
      scl_low <= 1'b0;
      sda_low <= 1'b0;
      z = 0;
      // long enough for the filter to pass the pulse and recover
      repeat (40) begin
        @(posedge ref_clk);
        z = z + ((sel == 0 ? scl_f : sda_f) === 1'b0);
      end
    end
  endtask
  task print_verdict;
    begin
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  initial begin
    #200000;
    fails = fails + 1;
    print_verdict;
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    apb(0, `ISCTF_ADDR_CLK, 0);
    chk(q, `ISCTF_CLK_RESET);
    apb(0, `ISCTF_ADDR_RISE, 0);
    chk(q, `ISCTF_RISE_RESET);
    apb(0, 8'h30, 0);
    chk(e, 1'b1);
    d = $random(seed);
    apb(1, `ISCTF_ADDR_RISE, d);
    apb(0, `ISCTF_ADDR_RISE, 0);
    chk(q, d & 32'hfffc_003f);
    chk({scl_af, scl_aw, sda_af, sda_aw}, d[31:26]);
    $display("test registers done");
    for (k = 0; k < 2; k = k + 1) begin
      // filters off first, then a random nonzero length on both lines
      g = k == 0 ? 0 : 2 + {$random(seed)} % 14;
      apb(1, `ISCTF_ADDR_RISE, 32'h3f | (g << 22) | (g << 18));
      for (w = 0; w < 2; w = w + 1) begin
        line_pulse(w, g > 0 ? g - 1 : 1);
        chk(z != 0, g == 0);
        line_pulse(w, g > 0 ? g : 1);
        chk(z != 0, 1);
      end
    end
    apb(0, `ISCTF_ADDR_STAT, 0);
    chk(q, 32'h3);
    $display("test glitch filter done");
    apb(1, `ISCTF_ADDR_CTRL, 1);
    apb(0, `ISCTF_ADDR_CTRL, 0);
    chk(q, 32'h1);
    repeat (20) @(posedge ref_clk);
    chk(scl_oe, 1'b0);
    $display("test slave mode done");
    for (m = 0; m < 3; m = m + 1) begin
      dv = m == 0 ? 4 + {$random(seed)} % 4
        : 1 + {$random(seed)} % 4;
      lo = (m == 0 ? 1 : m == 1 ? 2 : 16) * dv;
      hi = (m == 2 ? 9 : 1) * dv;
      // filter shorter than the low phase so the line is seen low
      f = {$random(seed)} % (m == 1 ? 2 : 4);
      stretch <= {$random(seed)} % 8;
      v = {16'h0, m != 0, m == 2, 2'h3, dv[11:0]};
      apb(1, `ISCTF_ADDR_CTRL, 0);
      apb(1, `ISCTF_ADDR_RISE, (f << 22) | (32'h30 + f));
      apb(1, `ISCTF_ADDR_CLK, v);
      apb(1, `ISCTF_ADDR_CTRL, 3);
      scl_phase;
      scl_phase;
      chk(l, lo);
      // release, stretch, filter delay, then the high count
      chk(h, hi + stretch + 2 + (f > 1 ? f : 1));
      apb(1, `ISCTF_ADDR_CLK, v ^ 32'h8003);
      apb(0, `ISCTF_ADDR_CLK, 0);
      chk(q, v & 32'hcfff);
    end
    $display("test scl timing done");
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk(scl_oe, 1'b0);
    reset <= 1'b0;
    apb(0, `ISCTF_ADDR_CLK, 0);
    chk(q, `ISCTF_CLK_RESET);
    apb(0, `ISCTF_ADDR_RISE, 0);
    chk(q, `ISCTF_RISE_RESET);
    $display("test reset done");
    print_verdict;
  end
endmodule
bind isctf_top isctf_sva chk_i (.ref_clk(ref_clk), .reset(reset),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .scl_in(scl_in), .sda_in(sda_in), .scl_out(scl_out), .scl_oe(scl_oe),
  .scl_filtered(scl_filtered), .sda_filtered(sda_filtered),
  .scl_analog_filter_off(scl_analog_filter_off),
  .scl_analog_filter_width(scl_analog_filter_width),
  .sda_analog_filter_off(sda_analog_filter_off),
  .sda_analog_filter_width(sda_analog_filter_width));
